// ==== logic/slpctl_pkg.sv ====
// Package: sleep mode controller constants and types
package slpctl_pkg;
    timeunit 1ns;
    timeprecision 100ps;
    // Sleep select encodings
    localparam logic [1:0] SEL_IDLE  = 2'h0;
    localparam logic [1:0] SEL_ADCNR = 2'h1;
    localparam logic [1:0] SEL_PDOWN = 2'h2;
    localparam logic [1:0] SEL_PSAVE = 2'h3;
    // Extra halt cycles after start-up
    localparam int          WAKE_EXTRA_CYC = 4;
    localparam logic [3:0]  WAKE_EXTRA     = 4'(WAKE_EXTRA_CYC);
    // Brown-out settle time and clock rate
    localparam int          BOD_SETTLE_US  = 60;
    localparam int          CLK_MHZ        = 125;
    localparam int          BOD_SETTLE_CYC = BOD_SETTLE_US * CLK_MHZ;
    // Timed write window for brown-out sleep-off bit
    localparam int          BROWNOUT_SLEEP_OFF_BIT_WIN_CYC   = 4;
    localparam logic [2:0]  BROWNOUT_SLEEP_OFF_BIT_WIN       = 3'(BROWNOUT_SLEEP_OFF_BIT_WIN_CYC);
    // Reset values
    localparam logic        BROWNOUT_SLEEP_OFF_BIT_RST       = 1'b0;
    localparam logic [15:0] CNT_ZERO       = 16'h0000;
    // Controller states
    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_START, ST_HOLD} slpctl_state_t;
endpackage

// ==== logic/slpctl_top.sv ====
// Sleep mode controller: clock gating, wake-up, brown-out sleep-off
module slpctl_top
    import slpctl_pkg::*;
#(
    parameter int BOD_SETTLE = BOD_SETTLE_CYC    // Shortened in simulation
) (
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    input  wire logic        SLEEP_ARM,          // Sleep arm bit
    input  wire logic [1:0]  SLEEP_SEL,          // Sleep select field
    input  wire logic        SLEEP_EXEC,         // Sleep instruction pulse
    input  wire logic        BROWNOUT_SLEEP_OFF_BIT_WR,            // Write strobe, control reg
    input  wire logic        BROWNOUT_SLEEP_OFF_BIT_WR_EN,         // Enable bit written value
    input  wire logic        BROWNOUT_SLEEP_OFF_BIT_WR_VAL,        // Sleep-off bit written value
    input  wire logic        BOD_FUSE_EN,        // Fuses enable detector
    input  wire logic [15:0] STARTUP_CYC,        // Start-up delay from clock select
    input  wire logic        ADC_ENABLE,         // Converter enabled
    input  wire logic        TIMER_ASYNC_SEL,    // Timer clocked asynchronously
    input  wire logic        GLOBAL_IE,          // Global interrupt enable
    input  wire logic        IRQ_ANY,            // Any enabled interrupt (idle)
    input  wire logic        IRQ_ADC_DONE,       // Conversion complete
    input  wire logic        IRQ_WDT,            // Watchdog interrupt
    input  wire logic        IRQ_USI_START,      // Serial start condition
    input  wire logic        IRQ_TMR_ASYNC,      // Async timer ovf/compare, enabled
    input  wire logic        IRQ_MEM_READY,      // Memory-ready interrupt
    input  wire logic        IRQ_PIN_CHANGE,     // Pin change interrupt
    input  wire logic [1:0]  EXT_IRQ_LEVEL,      // ext_irq_a/b level-mode requests
    input  wire logic        SLEEP_RST_REQ,      // Any reset source, synchronous
    output logic             CPU_CLK_EN,
    output logic             FLASH_CLK_EN,
    output logic             IO_CLK_EN,
    output logic             ADC_CLK_EN,
    output logic             ASYNC_CLK_EN,
    output logic             MAIN_OSC_EN,
    output logic             BOD_ENABLE,
    output logic             ADC_START,          // One-cycle conversion start
    output logic             CORE_HALT,          // Core stalled
    output logic             CORE_RESET_VEC,     // Restart from reset vector pulse
    output logic             IRQ_RESUME,         // Run handler then continue
    output logic             BROWNOUT_SLEEP_OFF_BIT_BIT,           // Sleep-off bit state
    output logic             TIMER_UNDEF         // Async timer contents suspect
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////
    // State and counters
    slpctl_state_t state_reg, state_next;   // Controller state
    logic [1:0]  mode_reg;                  // Mode latched at entry
    logic [15:0] cnt_reg, cnt_next;         // Delay counter
    logic        bod_off_reg;               // Detector off this sleep
    logic        brownout_sleep_off_bit_reg;                  // Sleep-off bit
    logic        wen_reg;                   // Timed-write window open
    logic [2:0]  win_reg;                   // Window countdown
    logic        undef_reg;                 // Timer undefined flag

    ////////////////////////////////////////////////////////////////
    // Decode
    // armed sleep entry
    wire enter    = (state_reg == ST_RUN) && SLEEP_EXEC && SLEEP_ARM;
    wire deep_sel = SLEEP_SEL[1];
    wire bod_cut  = enter && deep_sel && brownout_sleep_off_bit_reg;
    wire in_sleep = (state_reg == ST_SLEEP);
    // deep modes see level interrupts only
    wire lvl_wake = |EXT_IRQ_LEVEL;
    wire common_w = IRQ_WDT || IRQ_USI_START || lvl_wake || IRQ_PIN_CHANGE;
    logic wake;                             // Mode-qualified wake request
    always_comb begin
        unique case (mode_reg)
            SEL_IDLE:  wake = IRQ_ANY || common_w;
            SEL_ADCNR: wake = common_w || IRQ_ADC_DONE || IRQ_TMR_ASYNC || IRQ_MEM_READY;
            SEL_PDOWN: wake = common_w;
            SEL_PSAVE: wake = common_w || (IRQ_TMR_ASYNC && GLOBAL_IE && TIMER_ASYNC_SEL);
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        unique case (state_reg)
            ST_RUN: begin
                if (enter) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    state_next = ST_START;
                    cnt_next   = (bod_off_reg && (32'(STARTUP_CYC) < BOD_SETTLE))
                               ? 16'(BOD_SETTLE) : STARTUP_CYC;
                end
            end
            ST_START: begin
                if (cnt_reg == CNT_ZERO) begin
                    state_next = ST_HOLD;
                    cnt_next   = {12'h000, WAKE_EXTRA} - 16'h0001;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
            ST_HOLD: begin
                if (cnt_reg == CNT_ZERO) begin
                    state_next = ST_RUN;
                end else begin
                    cnt_next = cnt_reg - 16'h0001;
                end
            end
        endcase
        if (SLEEP_RST_REQ) begin
            state_next = ST_RUN;
            cnt_next   = CNT_ZERO;
        end
    end

    // State registers
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= ST_RUN;
            cnt_reg   <= CNT_ZERO;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Mode and detector-off latch at entry
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            mode_reg    <= SEL_IDLE;
            bod_off_reg <= 1'b0;
        end else if (enter) begin
            mode_reg    <= SLEEP_SEL;
            bod_off_reg <= bod_cut;
        end else if (in_sleep && wake) begin
            mode_reg    <= mode_reg;
            bod_off_reg <= bod_off_reg;
        end else if (state_reg == ST_RUN) begin
            bod_off_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Timed write of the sleep-off bit; enable opens a short window
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            brownout_sleep_off_bit_reg <= BROWNOUT_SLEEP_OFF_BIT_RST;
            wen_reg  <= 1'b0;
            win_reg  <= 3'h0;
        end else if (BROWNOUT_SLEEP_OFF_BIT_WR && BROWNOUT_SLEEP_OFF_BIT_WR_EN) begin
            wen_reg  <= 1'b1;
            win_reg  <= BROWNOUT_SLEEP_OFF_BIT_WIN - 3'h1;
        end else if (BROWNOUT_SLEEP_OFF_BIT_WR && wen_reg) begin
            brownout_sleep_off_bit_reg <= BROWNOUT_SLEEP_OFF_BIT_WR_VAL;
            wen_reg  <= 1'b0;
        end else if (wen_reg) begin
            wen_reg  <= (win_reg != 3'h0);
            win_reg  <= win_reg - 3'h1;
        end
    end

    // Timer contents flag: set on power-save wake without async clock
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            undef_reg <= 1'b0;
        end else if (in_sleep && wake && mode_reg == SEL_PSAVE && !TIMER_ASYNC_SEL) begin
            undef_reg <= 1'b1;
        end else if (enter) begin
            undef_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Clock gating; start-up and hold count as still sleeping domains
    wire asleep = (state_reg != ST_RUN);
    wire m_idle = asleep && mode_reg == SEL_IDLE;
    wire m_nr   = asleep && mode_reg == SEL_ADCNR;
    wire m_ps   = asleep && mode_reg == SEL_PSAVE;
    assign CPU_CLK_EN     = !asleep;
    assign FLASH_CLK_EN   = !asleep;
    assign IO_CLK_EN      = !asleep || m_idle;
    assign ADC_CLK_EN     = !asleep || m_idle || m_nr;
    assign ASYNC_CLK_EN   = !asleep || m_idle || m_nr || m_ps;
    assign MAIN_OSC_EN    = !asleep || m_idle || m_nr;
    assign BOD_ENABLE     = BOD_FUSE_EN && !(in_sleep && bod_off_reg);
    assign ADC_START      = enter && ADC_ENABLE && !deep_sel;
    assign CORE_HALT      = asleep;
    assign CORE_RESET_VEC = asleep && SLEEP_RST_REQ;
    assign IRQ_RESUME     = (state_reg == ST_HOLD) && (cnt_reg == CNT_ZERO) && !SLEEP_RST_REQ;
    assign BROWNOUT_SLEEP_OFF_BIT_BIT       = brownout_sleep_off_bit_reg;
    assign TIMER_UNDEF    = undef_reg;

    ////////////////////////////////////////////////////////////////
    // Assertions
    property p_entry;
        @(posedge SYS_CLK) disable iff (!NRST)
        (state_reg == ST_RUN && SLEEP_EXEC && SLEEP_ARM && !SLEEP_RST_REQ) |=> CORE_HALT;
    endproperty
    a_entry: assert property (p_entry) else $error("armed sleep not entered");
    property p_noarm;
        @(posedge SYS_CLK) disable iff (!NRST)
        (state_reg == ST_RUN && !SLEEP_ARM) |=> !CORE_HALT;
    endproperty
    a_noarm: assert property (p_noarm) else $error("unarmed sleep halted");
    property p_hold4;
        @(posedge SYS_CLK) disable iff (!NRST || SLEEP_RST_REQ)
        $rose(state_reg == ST_HOLD) |-> CORE_HALT [*4] ##1 !CORE_HALT;
    endproperty
    a_hold4: assert property (p_hold4) else $error("extra hold not four");
    property p_rst;
        @(posedge SYS_CLK) disable iff (!NRST)
        SLEEP_RST_REQ |=> state_reg == ST_RUN;
    endproperty
    a_rst: assert property (p_rst) else $error("reset did not wake");
    property p_bodoff;
        @(posedge SYS_CLK) disable iff (!NRST)
        (enter && SLEEP_SEL[1] && brownout_sleep_off_bit_reg && !SLEEP_RST_REQ) |=> !BOD_ENABLE;
    endproperty
    a_bodoff: assert property (p_bodoff) else $error("detector not off");
    property p_bodshallow;
        @(posedge SYS_CLK) disable iff (!NRST)
        (asleep && !mode_reg[1] && BOD_FUSE_EN) |-> BOD_ENABLE;
    endproperty
    a_bodshallow: assert property (p_bodshallow) else $error("detector off shallow");
    property p_idleclk;
        @(posedge SYS_CLK) disable iff (!NRST)
        m_idle |-> (!CPU_CLK_EN && IO_CLK_EN && ADC_CLK_EN && ASYNC_CLK_EN);
    endproperty
    a_idleclk: assert property (p_idleclk) else $error("idle gating wrong");
    property p_nrclk;
        @(posedge SYS_CLK) disable iff (!NRST)
        m_nr |-> (!IO_CLK_EN && ADC_CLK_EN && MAIN_OSC_EN);
    endproperty
    a_nrclk: assert property (p_nrclk) else $error("noise gating wrong");
    property p_psclk;
        @(posedge SYS_CLK) disable iff (!NRST)
        m_ps |-> (ASYNC_CLK_EN && !ADC_CLK_EN && !MAIN_OSC_EN);
    endproperty
    a_psclk: assert property (p_psclk) else $error("save gating wrong");
    property p_bodsw;
        @(posedge SYS_CLK) disable iff (!NRST)
        (BROWNOUT_SLEEP_OFF_BIT_WR && !BROWNOUT_SLEEP_OFF_BIT_WR_EN && !wen_reg) |=> $stable(BROWNOUT_SLEEP_OFF_BIT_BIT);
    endproperty
    a_bodsw: assert property (p_bodsw) else $error("untimed write took");
    property p_resume;
        @(posedge SYS_CLK) disable iff (!NRST)
        IRQ_RESUME |=> !CORE_HALT;
    endproperty
    a_resume: assert property (p_resume) else $error("core not released");
    property p_pdkeep;
        @(posedge SYS_CLK) disable iff (!NRST)
        (in_sleep && mode_reg == SEL_PDOWN && !common_w && !SLEEP_RST_REQ) |=> in_sleep;
    endproperty
    a_pdkeep: assert property (p_pdkeep) else $error("power-down woke unlisted");
    c_idle:  cover property (@(posedge SYS_CLK) disable iff (!NRST) enter && SLEEP_SEL == SEL_IDLE);
    c_wake:  cover property (@(posedge SYS_CLK) disable iff (!NRST) IRQ_RESUME);
    c_bod:   cover property (@(posedge SYS_CLK) disable iff (!NRST) bod_cut);
    c_rstsl: cover property (@(posedge SYS_CLK) disable iff (!NRST) CORE_RESET_VEC);

endmodule

// ==== verification/slpctl_bench.sv ====
// Bench: sleep controller driven through the core model
module slpctl_bench
    import slpctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int         SETTLE  = 20;          // Shortened brown-out settle
    localparam int         STARTUP = 6;           // Start-up delay in cycles
    localparam logic [5:0] MCLK [4] = '{6'h0F, 6'h07, 6'h00, 6'h02}; // Clocks per mode
    logic       clk = 1'b0;                       // System clock
    logic       nrst = 1'b0;                      // Active-low reset
    logic       wr = 1'b0;                        // Sleep-off write strobe
    logic       wen = 1'b0;                       // Enable bit value
    logic       wval = 1'b0;                      // Sleep-off value
    logic       fuse = 1'b1;                      // Detector fused on
    logic       adc_en = 1'b1;                    // Converter enabled
    logic       tsel = 1'b1;                      // Timer async select
    logic       gie = 1'b1;                       // Global interrupt enable
    logic       rst_req = 1'b0;                   // Reset request in sleep
    logic       brownout_sleep_off_bit_exp = 1'b0;                  // Expected sleep-off bit
    logic [8:0] src = 9'h000;                     // Wake sources, order as wired below
    logic       arm, exec, bod_en, adc_st, halt, rvec, resume, brownout_sleep_off_bit, tundef;
    logic [1:0] sel;                              // Mode from core
    logic [5:0] clks;                             // cpu flash io adc async osc
    int         fails = 0;
    int         comparisons = 0;
    int         adc_cnt = 0;                      // Conversion starts seen
    always #4 clk = ~clk;
    // Count conversion starts at the sampling edge
    always @(posedge clk) begin
        if (adc_st === 1'b1) begin
            adc_cnt <= adc_cnt + 1;
        end
    end
    slpctl_top #(.BOD_SETTLE(SETTLE)) dut (
        .SYS_CLK(clk), .NRST(nrst), .SLEEP_ARM(arm), .SLEEP_SEL(sel), .SLEEP_EXEC(exec),
        .BROWNOUT_SLEEP_OFF_BIT_WR(wr), .BROWNOUT_SLEEP_OFF_BIT_WR_EN(wen), .BROWNOUT_SLEEP_OFF_BIT_WR_VAL(wval), .BOD_FUSE_EN(fuse),
        .STARTUP_CYC(16'(STARTUP)), .ADC_ENABLE(adc_en), .TIMER_ASYNC_SEL(tsel), .GLOBAL_IE(gie),
        .IRQ_ANY(src[0]), .IRQ_ADC_DONE(src[1]), .IRQ_WDT(src[2]), .IRQ_USI_START(src[3]),
        .IRQ_TMR_ASYNC(src[4]), .IRQ_MEM_READY(src[5]), .IRQ_PIN_CHANGE(src[6]),
        .EXT_IRQ_LEVEL(src[8:7]), .SLEEP_RST_REQ(rst_req), .CPU_CLK_EN(clks[5]),
        .FLASH_CLK_EN(clks[4]), .IO_CLK_EN(clks[3]), .ADC_CLK_EN(clks[2]),
        .ASYNC_CLK_EN(clks[1]), .MAIN_OSC_EN(clks[0]), .BOD_ENABLE(bod_en),
        .ADC_START(adc_st), .CORE_HALT(halt), .CORE_RESET_VEC(rvec), .IRQ_RESUME(resume),
        .BROWNOUT_SLEEP_OFF_BIT_BIT(brownout_sleep_off_bit), .TIMER_UNDEF(tundef));
    slpctl_core_model core (.clk(clk), .resume(resume), .rvec(rvec), .arm(arm), .sel(sel),
        .exec(exec));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask
    // Single exit of the run
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Control register write, one strobe
    task automatic brownout_sleep_off_bit_write(input logic e, input logic v);
        @(negedge clk);
        wr = 1'b1;
        wen = e;
        wval = v;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // One sleep: refused sources first, then wake source b
    task automatic go(input logic [1:0] s, input logic [8:0] bad, input int b);
        int   c;
        int   r;
        int   a;
        logic off;
        off = brownout_sleep_off_bit_exp & fuse & s[1];
        a = adc_cnt;
        r = core.resumes;
        core.sleep(1'b1, s);
        check(halt, 1'b1);
        check(clks, MCLK[s]);
        check(bod_en, fuse & ~off);
        src = bad;
        repeat (8) @(negedge clk);
        check(halt, 1'b1);
        // source holds level across wake edge
        src = 9'h001 << b;
        @(negedge clk);
        src = 9'h000;
        c = 0;
        // Bounded wait for the core to run again
        while (halt === 1'b1 && c < 400) begin
            c++;
            @(negedge clk);
        end
        if (c == 400) begin
            fails++;
            print_verdict();
        end
        check(16'(c), 16'((off && SETTLE > STARTUP) ? SETTLE + 5 : STARTUP + 5));
        check(16'(core.resumes - r), 16'h0001);
        check(16'(adc_cnt - a), 16'(adc_en & ~s[1]));
        check(clks, 6'h3F);
        check(bod_en, fuse);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        check(brownout_sleep_off_bit, 1'b0);
        check(clks, 6'h3F);
        core.sleep(1'b0, SEL_IDLE);
        repeat (4) @(negedge clk);
        check(halt, 1'b0);
        go(SEL_IDLE, 9'h000, 0);
        // Every listed noise-mode source, general interrupt refused
        for (int b = 1; b < 9; b++) go(SEL_ADCNR, 9'h001, b);
        for (int b = 2; b < 9; b++) if (9'h1CC >> b & 1) go(SEL_PDOWN, 9'h033, b);
        for (int b = 2; b < 9; b++) if (9'h1DC >> b & 1) go(SEL_PSAVE, 9'h023, b);
        check(tundef, 1'b0);
        tsel = 1'b0;
        go(SEL_PSAVE, 9'h033, 2);
        check(tundef, 1'b1);
        tsel = 1'b1;
        // Timer wake needs global enable; no conversion with converter off
        adc_en = 1'b0;
        gie = 1'b0;
        go(SEL_PSAVE, 9'h033, 6);
        go(SEL_IDLE, 9'h000, 0);
        adc_en = 1'b1;
        gie = 1'b1;
        brownout_sleep_off_bit_write(1'b0, 1'b1);
        check(brownout_sleep_off_bit, 1'b0);
        brownout_sleep_off_bit_write(1'b1, 1'b0);
        brownout_sleep_off_bit_write(1'b0, 1'b1);
        brownout_sleep_off_bit_exp = 1'b1;
        check(brownout_sleep_off_bit, 1'b1);
        go(SEL_IDLE, 9'h000, 0);
        go(SEL_ADCNR, 9'h000, 1);
        go(SEL_PDOWN, 9'h000, 2);
        // Reset request while asleep restarts the core
        core.sleep(1'b1, SEL_PDOWN);
        rst_req = 1'b1;
        #1 check(rvec, 1'b1);
        @(negedge clk);
        check(halt, 1'b0);
        rst_req = 1'b0;
        nrst = 1'b0;
        fuse = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        brownout_sleep_off_bit_exp = 1'b0;
        check(brownout_sleep_off_bit, 1'b0);
        check(bod_en, 1'b0);
        go(SEL_PSAVE, 9'h000, 4);
        print_verdict();
    end
endmodule

// ==== verification/slpctl_core_model.sv ====
// Core model: arms sleep, runs the sleep instruction, counts resumes
module slpctl_core_model (
    input  wire logic       clk,       // System clock
    input  wire logic       resume,    // Handler entry, then continue
    input  wire logic       rvec,      // Restart from reset vector
    output logic            arm,       // Sleep arm bit
    output logic [1:0]      sel,       // Sleep select field
    output logic            exec       // Sleep instruction pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    int resumes = 0;                   // Handler entries seen
    // Core idles with nothing armed
    initial begin
        arm = 1'b0;
        sel = 2'h0;
        exec = 1'b0;
    end
    task automatic sleep(input logic a, input logic [1:0] s);
        @(negedge clk);
        arm = a;
        sel = s;
        exec = 1'b1;
        @(negedge clk);
        exec = 1'b0;
    endtask
    always @(posedge clk) begin
        if (resume === 1'b1 || rvec === 1'b1) begin
            arm <= 1'b0;
            resumes <= resumes + ((resume === 1'b1) ? 1 : 0);
        end
    end
endmodule
